// ---- inc/tmq_pkg.sv ----
// constants, field layout and state type of the transmit descriptor queue engine
package tmq_pkg;
  localparam int NQ = 16;
  localparam logic [11:0] HDP_BASE = 12'h500;
  localparam logic [11:0] CP_BASE = 12'h580;
  localparam logic [31:0] WORD3_OFS = 32'h0000000c;
  localparam logic [31:0] WORD_STEP = 32'h00000004;
  // descriptor word 2
  localparam int W2_DEST_LSB = 16;
  localparam int W2_PRI_LSB = 14;
  localparam int W2_TT_LSB = 12;
  localparam int W2_PORT_LSB = 10;
  localparam int W2_SEGMENT_SIZE_CODE_LSB = 6;
  localparam int W2_MBOX_LSB = 0;
  // descriptor word 3
  localparam int W3_SOP = 31;
  localparam int W3_EOP = 30;
  localparam int W3_OWN = 29;
  localparam int W3_EOQ = 28;
  localparam int W3_TDOWN = 27;
  localparam int W3_RETRY_LSB = 12;
  localparam int W3_CC_LSB = 9;
  localparam int W3_LEN_LSB = 0;
  // completion codes, also the response kinds from the link side
  localparam logic [2:0] CC_DONE = 3'h0;
  localparam logic [2:0] CC_ERROR = 3'h1;
  localparam logic [2:0] CC_RETRIES = 3'h2;
  localparam logic [2:0] CC_TIMEOUT = 3'h3;
  localparam logic [2:0] CC_DMAERR = 3'h4;
  localparam logic [2:0] RSP_RETRY = 3'h2;
  localparam logic [31:0] HDP_RESET = 32'h00000000;
  localparam logic [31:0] CP_RESET = 32'h00000000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FETCH = 3'h1,
    ST_SEND = 3'h2,
    ST_WAIT = 3'h3,
    ST_WB = 3'h4
  } tmq_state_t;
endpackage

// ---- hw/tmq_engine.sv ----
// transmit message descriptor queue engine
`timescale 1ns/1ps
`default_nettype none
module tmq_engine (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic hdp_write_err,
  output logic [3:0] hdp_err_queue,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic msg_valid,
  input wire logic msg_ready,
  output logic [1:0] output_port_select,
  output logic [15:0] target_node_id,
  output logic [1:0] msg_priority,
  output logic [1:0] id_size_type,
  output logic [3:0] segment_size_code,
  output logic [5:0] msg_mailbox,
  output logic [31:0] msg_buf_addr,
  output logic [8:0] msg_length,
  output logic [3:0] msg_queue,
  input wire logic rsp_valid,
  input wire logic [2:0] rsp_kind,
  output logic [15:0] queue_irq
);
  // register window decode: word slot inside a 16-word block
  function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] base);
    reg_hit = (a[11:6] == base[11:6]) && (a[1:0] == 2'h0);
  endfunction

  // lowest numbered queue with work
  function automatic logic [3:0] first_busy(input logic [15:0] v);
    first_busy = 4'h0;
    for (int k = tmq_pkg::NQ - 1; k >= 0; k--) begin
      if (v[k]) begin
        first_busy = k[3:0];
      end
    end
  endfunction

  tmq_pkg::tmq_state_t st_r, st_nxt;
  logic [31:0] hdp_r [16];
  logic [31:0] hdp_nxt [16];
  logic [31:0] cp_r [16];
  logic [31:0] cp_nxt [16];
  logic [31:0] last_r [16];
  logic [31:0] last_nxt [16];
  logic [15:0] pend_r, pend_nxt;
  logic [31:0] wd_r [4];
  logic [31:0] wd_nxt [4];
  logic [3:0] q_r, q_nxt;
  logic [31:0] desc_r, desc_nxt;
  logic [1:0] w_r, w_nxt;
  logic [5:0] left_r, left_nxt;
  logic [31:0] maddr_r, maddr_nxt;
  logic [31:0] mwdata_r, mwdata_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic err_r, err_nxt;
  logic [3:0] errq_r, errq_nxt;
  logic [15:0] busy;
  logic [5:0] budget;
  logic [31:0] w3;
  logic [3:0] idx;

  assign idx = cfg_addr[5:2];
  assign budget = wd_r[3][tmq_pkg::W3_RETRY_LSB +: 6];

  always_comb begin
    for (int i = 0; i < tmq_pkg::NQ; i++) begin
      busy[i] = (hdp_r[i] != 32'h00000000);
    end
  end

  // next state of the queue engine and of the register file
  always_comb begin
    st_nxt = st_r;
    hdp_nxt = hdp_r;
    cp_nxt = cp_r;
    last_nxt = last_r;
    pend_nxt = pend_r;
    wd_nxt = wd_r;
    q_nxt = q_r;
    desc_nxt = desc_r;
    w_nxt = w_r;
    left_nxt = left_r;
    maddr_nxt = maddr_r;
    mwdata_nxt = mwdata_r;
    err_nxt = 1'b0;
    errq_nxt = errq_r;
    rvalid_nxt = cfg_rd;
    rdata_nxt = 32'h00000000;
    w3 = wd_r[3];
    case (st_r)
      tmq_pkg::ST_IDLE: begin
        if (|busy) begin
          q_nxt = first_busy(busy);
          desc_nxt = hdp_r[first_busy(busy)];
          maddr_nxt = hdp_r[first_busy(busy)];
          w_nxt = 2'h0;
          st_nxt = tmq_pkg::ST_FETCH;
        end
      end
      tmq_pkg::ST_FETCH: begin
        if (mem_ack) begin
          wd_nxt[w_r] = mem_rdata;
          maddr_nxt = maddr_r + tmq_pkg::WORD_STEP;
          w_nxt = w_r + 2'h1;
          if (w_r == 2'h3) begin
            left_nxt = mem_rdata[tmq_pkg::W3_RETRY_LSB +: 6];
            // not yet handed over: leave the queue pending and look again
            st_nxt = mem_rdata[tmq_pkg::W3_OWN] ? tmq_pkg::ST_SEND : tmq_pkg::ST_IDLE;
          end
        end
      end
      tmq_pkg::ST_SEND: begin
        if (msg_ready) begin
          st_nxt = tmq_pkg::ST_WAIT;
        end
      end
      tmq_pkg::ST_WAIT: begin
        if (rsp_valid) begin
          w3[tmq_pkg::W3_SOP] = 1'b1;
          w3[tmq_pkg::W3_EOP] = 1'b1;
          w3[tmq_pkg::W3_OWN] = 1'b0;
          w3[tmq_pkg::W3_EOQ] = (wd_r[0] == 32'h00000000);
          w3[tmq_pkg::W3_TDOWN] = 1'b0;
          w3[tmq_pkg::W3_RETRY_LSB +: 6] = left_r;
          w3[tmq_pkg::W3_CC_LSB +: 3] = rsp_kind;
          maddr_nxt = desc_r + tmq_pkg::WORD3_OFS;
          mwdata_nxt = w3;
          st_nxt = tmq_pkg::ST_WB;
          if (rsp_kind == tmq_pkg::RSP_RETRY) begin
            if (budget == 6'h00) begin
              st_nxt = tmq_pkg::ST_SEND;
            end else if (left_r != 6'h00) begin
              left_nxt = left_r - 6'h01;
              st_nxt = tmq_pkg::ST_SEND;
            end else begin
              w3[tmq_pkg::W3_CC_LSB +: 3] = tmq_pkg::CC_RETRIES;
              mwdata_nxt = w3;
            end
          end
        end
      end
      tmq_pkg::ST_WB: begin
        if (mem_ack) begin
          hdp_nxt[q_r] = wd_r[0];
          last_nxt[q_r] = desc_r;
          st_nxt = tmq_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt = tmq_pkg::ST_IDLE;
      end
    endcase
    // register reads
    if (cfg_rd && reg_hit(cfg_addr, tmq_pkg::HDP_BASE)) begin
      rdata_nxt = hdp_r[idx];
    end else if (cfg_rd && reg_hit(cfg_addr, tmq_pkg::CP_BASE)) begin
      rdata_nxt = cp_r[idx];
    end
    // host writes; a busy head pointer refuses the write
    if (cfg_wr && reg_hit(cfg_addr, tmq_pkg::HDP_BASE)) begin
      if (busy[idx]) begin
        err_nxt = 1'b1;
        errq_nxt = idx;
      end else begin
        hdp_nxt[idx] = cfg_wdata;
      end
    end
    if (cfg_wr && reg_hit(cfg_addr, tmq_pkg::CP_BASE)) begin
      cp_nxt[idx] = cfg_wdata;
      if (cfg_wdata == last_r[idx]) begin
        pend_nxt[idx] = 1'b0;
      end
    end
    // a completion in the same cycle wins over the host clear
    if (st_r == tmq_pkg::ST_WB && mem_ack) begin
      pend_nxt[q_r] = 1'b1;
    end
  end

  // state registers, all cleared by reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= tmq_pkg::ST_IDLE;
      for (int i = 0; i < tmq_pkg::NQ; i++) begin
        hdp_r[i] <= tmq_pkg::HDP_RESET;
        cp_r[i] <= tmq_pkg::CP_RESET;
        last_r[i] <= 32'h00000000;
      end
      for (int j = 0; j < 4; j++) begin
        wd_r[j] <= 32'h00000000;
      end
      pend_r <= 16'h0000;
      q_r <= 4'h0;
      desc_r <= 32'h00000000;
      w_r <= 2'h0;
      left_r <= 6'h00;
      maddr_r <= 32'h00000000;
      mwdata_r <= 32'h00000000;
      rdata_r <= 32'h00000000;
      rvalid_r <= 1'b0;
      err_r <= 1'b0;
      errq_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      hdp_r <= hdp_nxt;
      cp_r <= cp_nxt;
      last_r <= last_nxt;
      wd_r <= wd_nxt;
      pend_r <= pend_nxt;
      q_r <= q_nxt;
      desc_r <= desc_nxt;
      w_r <= w_nxt;
      left_r <= left_nxt;
      maddr_r <= maddr_nxt;
      mwdata_r <= mwdata_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      err_r <= err_nxt;
      errq_r <= errq_nxt;
    end
  end

  // outputs
  assign mem_req = (st_r == tmq_pkg::ST_FETCH) || (st_r == tmq_pkg::ST_WB);
  assign mem_we = (st_r == tmq_pkg::ST_WB);
  assign mem_addr = maddr_r;
  assign mem_wdata = mwdata_r;
  assign msg_valid = (st_r == tmq_pkg::ST_SEND);
  assign output_port_select = wd_r[2][tmq_pkg::W2_PORT_LSB +: 2];
  assign target_node_id = wd_r[2][tmq_pkg::W2_DEST_LSB +: 16];
  assign msg_priority = wd_r[2][tmq_pkg::W2_PRI_LSB +: 2];
  assign id_size_type = wd_r[2][tmq_pkg::W2_TT_LSB +: 2];
  assign segment_size_code = wd_r[2][tmq_pkg::W2_SEGMENT_SIZE_CODE_LSB +: 4];
  assign msg_mailbox = wd_r[2][tmq_pkg::W2_MBOX_LSB +: 6];
  assign msg_buf_addr = wd_r[1];
  assign msg_length = wd_r[3][tmq_pkg::W3_LEN_LSB +: 9];
  assign msg_queue = q_r;
  assign cfg_rdata = rdata_r;
  assign cfg_rvalid = rvalid_r;
  assign hdp_write_err = err_r;
  assign hdp_err_queue = errq_r;
  assign queue_irq = pend_r;

  // checks
  a_fetch_aligned: assert property (@(posedge mclk) disable iff (rst)
    mem_req |-> mem_addr[1:0] == 2'h0) else $error("descriptor access unaligned");
  a_port_route: assert property (@(posedge mclk) disable iff (rst)
    msg_valid && !msg_ready |=> msg_valid && $stable(output_port_select))
    else $error("port moved while offered");
  a_hdp_err_flag: assert property (@(posedge mclk) disable iff (rst)
    cfg_wr && reg_hit(cfg_addr, tmq_pkg::HDP_BASE) && busy[idx] |=> hdp_write_err
    && hdp_err_queue == $past(idx)) else $error("busy head write not flagged");
  a_hdp_drain: assert property (@(posedge mclk) disable iff (rst)
    mem_we && mem_ack && wd_r[0] == 32'h00000000 |=> hdp_r[$past(q_r)] == 32'h00000000)
    else $error("head pointer not cleared");
  a_wb_flags: assert property (@(posedge mclk) disable iff (rst)
    mem_we |-> mem_wdata[31] && mem_wdata[30] && !mem_wdata[29]) else $error("bad flags");
  a_eoq_mark: assert property (@(posedge mclk) disable iff (rst)
    mem_we |-> mem_wdata[28] == (wd_r[0] == 32'h00000000)) else $error("bad drained flag");
  a_cc_legal: assert property (@(posedge mclk) disable iff (rst)
    mem_we |-> mem_wdata[11:9] <= 3'h4) else $error("illegal completion code");
  a_retry_count: assert property (@(posedge mclk) disable iff (rst)
    st_r == tmq_pkg::ST_WAIT && rsp_valid && rsp_kind == 3'h2 && budget != 6'h00
    && left_r != 6'h00 |=> left_r == $past(left_r) - 6'h01 && msg_valid)
    else $error("retry budget not decremented");
  a_irq_clear: assert property (@(posedge mclk) disable iff (rst)
    cfg_wr && reg_hit(cfg_addr, tmq_pkg::CP_BASE) && cfg_wdata == last_r[idx]
    && !(mem_we && mem_ack && q_r == idx) |=> !queue_irq[$past(idx)])
    else $error("interrupt not dropped");
  a_next_follow: assert property (@(posedge mclk) disable iff (rst)
    mem_we && mem_ack |=> hdp_r[$past(q_r)] == $past(wd_r[0])) else $error("link lost");
  c_done: cover property (@(posedge mclk) disable iff (rst) mem_we && mem_ack);
  c_unowned: cover property (@(posedge mclk) disable iff (rst)
    st_r == tmq_pkg::ST_FETCH && mem_ack && w_r == 2'h3 && !mem_rdata[tmq_pkg::W3_OWN]);
  c_retry: cover property (@(posedge mclk) disable iff (rst)
    st_r == tmq_pkg::ST_WAIT && rsp_valid && rsp_kind == 3'h2);
  c_hdp_err: cover property (@(posedge mclk) disable iff (rst) hdp_write_err);
endmodule // tmq_engine
`default_nettype wire

// ---- bench/tmq_mem_model.sv ----
// descriptor memory model answering the engine's word accesses
`timescale 1ns/1ps
`default_nettype none
module tmq_mem_model (
  input wire logic mclk,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] words [0:255];
  int n_rd;
  int wait_n;
  logic taken;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    n_rd = 0;
    wait_n = 0;
  end
  // sample at the edge, answer just after it; rdata scrambles after each taken access and while no request is open
  always @(posedge mclk) begin
    taken = mem_req && mem_ack;
    if (taken && mem_we) words[mem_addr[9:2]] = mem_wdata;
    if (taken && !mem_we) n_rd++;
    #1;
    if (taken || !mem_req) begin
      mem_ack = 1'b0;
      mem_rdata = ~mem_rdata;
      wait_n = 0;
    end else if (wait_n < (slow ? 3 : 0)) begin
      wait_n++;
    end else begin
      mem_ack = 1'b1;
      mem_rdata = mem_we ? ~mem_rdata : words[mem_addr[9:2]];
    end
  end
endmodule // tmq_mem_model
`default_nettype wire

// ---- bench/test_tx_message_descriptor_queue.sv ----
// bench for the transmit descriptor queue engine
`timescale 1ns/1ps
`default_nettype none
module test_tx_message_descriptor_queue;
  logic mclk, rst, cfg_wr, cfg_rd, cfg_rvalid, hdp_write_err, mem_req, mem_we, mem_ack;
  logic msg_valid, msg_ready, rsp_valid, slow;
  logic [11:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, mem_addr, mem_wdata, mem_rdata, msg_buf_addr, rv;
  logic [1:0] output_port_select, msg_priority, id_size_type;
  logic [15:0] target_node_id, queue_irq;
  logic [3:0] hdp_err_queue, segment_size_code, msg_queue;
  logic [5:0] msg_mailbox;
  logic [8:0] msg_length;
  logic [2:0] rsp_kind;
  int err_total, checks_done;
  logic [2:0] k1 [0:4] = '{3'h1, 3'h3, 3'h4, 3'h2, 3'h2};
  logic [2:0] k2 [0:4] = '{3'h0, 3'h0, 3'h0, 3'h2, 3'h0};
  logic [2:0] ecc [0:4] = '{3'h1, 3'h3, 3'h4, 3'h2, 3'h0};
  logic [5:0] bud [0:4] = '{6'h01, 6'h01, 6'h01, 6'h01, 6'h00};
  logic [5:0] rem [0:4] = '{6'h01, 6'h01, 6'h01, 6'h00, 6'h00};
  tmq_engine uut (.mclk, .rst, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata, .cfg_rvalid,
    .hdp_write_err, .hdp_err_queue, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata, .msg_valid, .msg_ready, .output_port_select, .target_node_id, .msg_priority,
    .id_size_type, .segment_size_code, .msg_mailbox, .msg_buf_addr, .msg_length, .msg_queue,
    .rsp_valid, .rsp_kind, .queue_irq);
  tmq_mem_model mem (.mclk, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    tick();
    cfg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    cfg_addr = a;
    cfg_rd = 1'b1;
    tick();
    cfg_rd = 1'b0;
    d = cfg_rdata;
    chk(cfg_rvalid, 1'b1, "read not answered");
    tick();
  endtask
  // host side: build one descriptor in memory, ownership handed over
  task automatic put_desc(input int a, input logic [31:0] lnk, input logic [31:0] b,
                          input logic [1:0] p, input logic [5:0] bg);
    mem.words[a/4] = lnk;
    mem.words[a/4+1] = b;
    mem.words[a/4+2] = {16'h1234, 2'h1, 2'h0, p, 4'h3, 6'h05};
    mem.words[a/4+3] = {2'h0, 1'b1, 11'h000, bg, 3'h0, 9'h040};
  endtask
  // link side: accept the offered message and answer with kind k
  task automatic send(input logic [2:0] k, input logic [1:0] p, input logic [31:0] b,
                      input logic [3:0] q);
    int n;
    n = 0;
    while (msg_valid !== 1'b1 && n < 100) begin
      tick();
      n++;
    end
    chk(msg_valid, 1'b1, "no message offered");
    chk({output_port_select, msg_buf_addr, msg_queue}, {p, b, q}, "message fields");
    chk({target_node_id, msg_priority, id_size_type, segment_size_code, msg_mailbox, msg_length},
        {16'h1234, 2'h1, 2'h0, 4'h3, 6'h05, 9'h040}, "routing fields");
    msg_ready = 1'b1;
    tick();
    msg_ready = 1'b0;
    rsp_kind = k;
    rsp_valid = 1'b1;
    tick();
    rsp_valid = 1'b0;
  endtask
  task automatic idle_wait(input logic [11:0] a);
    int n;
    n = 0;
    rv = 32'h1;
    while (rv !== 32'h0 && n < 100) begin
      rd(a, rv);
      n++;
    end
    chk(rv, 32'h0, "head pointer not cleared");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog well past the expected run length
  initial begin
    #200000;
    err_total++;
    final_report();
  end
  initial begin
    {cfg_wr, cfg_rd, msg_ready, rsp_valid, slow} = 5'h00;
    cfg_addr = 12'h000;
    cfg_wdata = 32'h0;
    rsp_kind = 3'h0;
    err_total = 0;
    checks_done = 0;
    rst = 1'b1;
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    rd(12'h50c, rv); chk(rv, 32'h0, "head pointer reset");
    rd(12'h5bc, rv); chk(rv, 32'h0, "completion pointer reset");
    rd(12'h7f0, rv); chk(rv, 32'h0, "unmapped read");
    $display("test reset values done");
    put_desc(32'h40, 32'h80, 32'h2003, 2'h2, 6'h02);
    put_desc(32'h80, 32'h0, 32'h3001, 2'h1, 6'h00);
    wr(12'h50c, 32'h40); chk(hdp_write_err, 1'b0, "clean start refused");
    tick();
    wr(12'h50c, 32'h80); chk({hdp_write_err, hdp_err_queue}, 5'h13, "busy write");
    send(3'h2, 2'h2, 32'h2003, 4'h3);
    send(3'h0, 2'h2, 32'h2003, 4'h3);
    send(3'h1, 2'h1, 32'h3001, 4'h3);
    idle_wait(12'h50c);
    chk(mem.words[19], {3'b110, 1'b0, 10'h0, 6'h01, 3'h0, 9'h040}, "first write-back");
    chk(mem.words[35], {3'b110, 1'b1, 10'h0, 6'h00, 3'h1, 9'h040}, "last write-back");
    chk(32'(mem.n_rd), 32'h8, "descriptor fetch count");
    chk(queue_irq[3], 1'b1, "irq after completion");
    wr(12'h58c, 32'h40); tick(); chk(queue_irq[3], 1'b1, "irq dropped early");
    wr(12'h58c, 32'h80); tick(); chk(queue_irq[3], 1'b0, "irq kept");
    rd(12'h58c, rv); chk(rv, 32'h80, "completion pointer readback");
    $display("test chained queue done");
    slow = 1'b1;
    for (int i = 0; i < 5; i++) begin
      put_desc(32'h100, 32'h0, 32'h4000 + i, 2'(i), bud[i]);
      wr(12'h500 + 12'(4 * i), 32'h100);
      send(k1[i], 2'(i), 32'h4000 + i, 4'(i));
      if (k1[i] == 3'h2) send(k2[i], 2'(i), 32'h4000 + i, 4'(i));
      idle_wait(12'h500 + 12'(4 * i));
      chk(mem.words[67], {3'b110, 1'b1, 10'h0, rem[i], ecc[i], 9'h040}, "status");
    end
    chk(queue_irq[4:0], 5'h1f, "irq per queue");
    // descriptor not yet handed over: engine must hold the queue and wait
    put_desc(32'h100, 32'h0, 32'h4005, 2'h1, 6'h00);
    mem.words[67][29] = 1'b0;
    wr(12'h514, 32'h100);
    repeat (30) tick();
    chk(msg_valid, 1'b0, "unowned descriptor offered");
    rd(12'h514, rv);
    chk(rv, 32'h100, "unowned queue dropped");
    mem.words[67][29] = 1'b1;
    send(3'h0, 2'h1, 32'h4005, 4'h5);
    idle_wait(12'h514);
    chk(queue_irq[5], 1'b1, "irq after late handover");
    $display("test completion codes done");
    final_report();
  end
endmodule // test_tx_message_descriptor_queue
`default_nettype wire
